// *** slz_core.v ***
// shaft limit positions, door zones and persistent error level logic
// Behaviour
// (RL1) normal/adjust: upper final limit = highest flush plus offset 30..100, default 50
// (RL2) teach with temp references: upper final limit = upper temp reference
// (RL3) normal/adjust: lower final limit = lowest flush minus offset 30..100, default 50
// (RL4) teach with temp references: lower final limit = lower temp reference
// (RL5) upper inspection = highest flush (teach: upper ref) minus 1300..10000
// (RL6) lower inspection = lowest flush (teach: lower ref) plus 1700..10000
// (RL7) levelling zone is flush plus/minus size 20..350, default 200
// (RL8) re-levelling zone is flush plus/minus size 20..200, default 140
// (RL9) buzzer and led on within 2000..4000 mm of an inspection limit
// (RL10) parameter writes taken only when inside the allowed range
// (RL11) every settable parameter reads back its present value
// (RL12) level 1 stops travel, then becomes level 2 at standstill
// (RL13) level 2 opens primary, 3 adds secondary, 4 adds governor
// (RL14) error level is kept in non-volatile store until manual reset
// (RL15) current level held in two defect registers, one per channel
// (RL16) both defect registers also hold the level found at start-up
// (RL17) teach and adjust requests are refused while an error is active
// (RL18) power loss leaves every contact open
// (RL19) controller reads the current level over the bus for display
// (RL20) manual reset needs three short presses with short gaps
// (RL21) a lower severity defect never lowers the set level
//
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "slz_defines.vh"
module slz_core #(
   parameter PW      = 24,
   parameter CNT_MAX = `SLZ_PRESS_MAX_MS * `SLZ_CLK_KHZ
) (
   input  wire          i_ref_clk,
   input  wire          i_rst,
   input  wire [7:0]    i_addr,
   input  wire [31:0]   i_wdata,
   input  wire          i_wr,
   input  wire          i_rd,
   output reg  [31:0]   o_rdata,
   input  wire [PW-1:0] i_pos,
   input  wire [PW-1:0] i_flush_high,
   input  wire [PW-1:0] i_flush_low,
   input  wire [PW-1:0] i_flush_near,
   input  wire [PW-1:0] i_ref_upper,
   input  wire [PW-1:0] i_ref_lower,
   input  wire          i_ref_valid,
   input  wire          i_moving,
   input  wire          i_defect,
   input  wire [2:0]    i_defect_level,
   input  wire [2:0]    i_nv_level,
   input  wire          i_nv_valid,
   output reg           o_nv_write,
   output reg  [2:0]    o_nv_level,
   input  wire          i_reset_btn,
   output reg           o_stop_travel,
   output wire          o_primary_actuator_contact,
   output wire          o_secondary_actuator_contact,
   output wire          o_governor_actuator_contact,
   output reg           o_in_level_zone,
   output reg           o_in_relevel_zone,
   output reg           o_buzzer,
   output reg           o_led,
   output wire [1:0]    o_mode
);
   // -----------------------------
   // settable parameters and mode
   // -----------------------------
   reg [15:0] uf_ofs;
   reg [15:0] lf_ofs;
   reg [15:0] ui_ofs;
   reg [15:0] li_ofs;
   reg [15:0] lvl_zone;
   reg [15:0] relvl_zone;
   reg [15:0] ind_dist;
   reg [1:0]  mode;
   reg [2:0]  level_a;
   reg [2:0]  level_b;
   reg [2:0]  start_level;
   reg        started;
   reg        contacts_ok;
   reg [PW-1:0] uf_pos;
   reg [PW-1:0] lf_pos;
   reg [PW-1:0] ui_pos;
   reg [PW-1:0] li_pos;
   reg [2:0]  next_level;
   wire       reset_ok;
   // set upper bits make the word out of range: all ones lies above every maximum
   wire [15:0] wv = (i_wdata[31:16] == 16'h0) ? i_wdata[15:0] : 16'hffff;
   wire       teach_ref = (mode == `SLZ_MODE_TEACH) && i_ref_valid;
   wire       err_on    = (level_a != `SLZ_LVL_NONE);

   slz_reset_seq #(
      .CNT_MAX (CNT_MAX)
   ) slz_reset_seq_i (
      .i_ref_clk  (i_ref_clk),
      .i_rst      (i_rst),
      .i_btn      (i_reset_btn),
      .o_reset_ok (reset_ok)
   );

   // range check on every parameter write; out of range values are dropped silently
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         uf_ofs     <= `SLZ_FIN_DEF;
         lf_ofs     <= `SLZ_FIN_DEF;
         ui_ofs     <= `SLZ_UI_DEF;
         li_ofs     <= `SLZ_LI_DEF;
         lvl_zone   <= `SLZ_LZ_DEF;
         relvl_zone <= `SLZ_RZ_DEF;
         ind_dist   <= `SLZ_IND_DEF;
         mode       <= `SLZ_MODE_NORMAL;
      end else if (i_wr) begin
         if (i_addr == `SLZ_REG_UF_OFS) begin
            if (wv >= `SLZ_FIN_MIN && wv <= `SLZ_FIN_MAX) uf_ofs <= wv; // RL10
         end else if (i_addr == `SLZ_REG_LF_OFS) begin
            if (wv >= `SLZ_FIN_MIN && wv <= `SLZ_FIN_MAX) lf_ofs <= wv; // RL10
         end else if (i_addr == `SLZ_REG_UI_OFS) begin
            if (wv >= `SLZ_UI_MIN && wv <= `SLZ_UI_MAX) ui_ofs <= wv; // RL10
         end else if (i_addr == `SLZ_REG_LI_OFS) begin
            if (wv >= `SLZ_LI_MIN && wv <= `SLZ_LI_MAX) li_ofs <= wv; // RL10
         end else if (i_addr == `SLZ_REG_LVL_ZONE) begin
            if (wv >= `SLZ_LZ_MIN && wv <= `SLZ_LZ_MAX) lvl_zone <= wv; // RL10
         end else if (i_addr == `SLZ_REG_RELVL_ZONE) begin
            if (wv >= `SLZ_RZ_MIN && wv <= `SLZ_RZ_MAX) relvl_zone <= wv; // RL10
         end else if (i_addr == `SLZ_REG_IND_DIST) begin
            if (wv >= `SLZ_IND_MIN && wv <= `SLZ_IND_MAX) ind_dist <= wv; // RL10
         end else if (i_addr == `SLZ_REG_MODE) begin
            // only normal mode may be entered while an error stands
            if (i_wdata[1:0] == `SLZ_MODE_NORMAL)
               mode <= `SLZ_MODE_NORMAL;
            else if (!err_on && (i_wdata[1:0] == `SLZ_MODE_ADJUST || i_wdata[1:0] == `SLZ_MODE_TEACH))
               mode <= i_wdata[1:0]; // RL17
         end
      end
   end
   assign o_mode = mode;

   // -----------------------------
   // limit positions
   // -----------------------------
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         uf_pos <= {PW{1'b0}};
         lf_pos <= {PW{1'b0}};
         ui_pos <= {PW{1'b0}};
         li_pos <= {PW{1'b0}};
      end else if (teach_ref) begin
         uf_pos <= i_ref_upper; // RL2
         lf_pos <= i_ref_lower; // RL4
         ui_pos <= i_ref_upper - {{(PW-16){1'b0}}, ui_ofs}; // RL5
         li_pos <= i_ref_lower + {{(PW-16){1'b0}}, li_ofs}; // RL6
      end else begin
         uf_pos <= i_flush_high + {{(PW-16){1'b0}}, uf_ofs}; // RL1
         lf_pos <= i_flush_low - {{(PW-16){1'b0}}, lf_ofs}; // RL3
         ui_pos <= i_flush_high - {{(PW-16){1'b0}}, ui_ofs}; // RL5
         li_pos <= i_flush_low + {{(PW-16){1'b0}}, li_ofs}; // RL6
      end
   end

   // -----------------------------
   // door zones and limit indicator
   // -----------------------------
   // distance to nearest flush and to each inspection limit, unsigned magnitude
   wire [PW-1:0] d_flush = (i_pos >= i_flush_near) ? i_pos - i_flush_near : i_flush_near - i_pos;
   wire [PW-1:0] d_ui    = (i_pos >= ui_pos) ? i_pos - ui_pos : ui_pos - i_pos;
   wire [PW-1:0] d_li    = (i_pos >= li_pos) ? i_pos - li_pos : li_pos - i_pos;
   wire [PW-1:0] ind_w   = {{(PW-16){1'b0}}, ind_dist};
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_in_level_zone   <= 1'b0;
         o_in_relevel_zone <= 1'b0;
         o_buzzer          <= 1'b0;
         o_led             <= 1'b0;
      end else begin
         o_in_level_zone   <= d_flush <= {{(PW-16){1'b0}}, lvl_zone}; // RL7
         o_in_relevel_zone <= d_flush <= {{(PW-16){1'b0}}, relvl_zone}; // RL8
         o_buzzer          <= (d_ui <= ind_w) || (d_li <= ind_w); // RL9
         o_led             <= (d_ui <= ind_w) || (d_li <= ind_w); // RL9
      end
   end

   // -----------------------------
   // error level
   // -----------------------------
   // the new defect wins over a manual reset in the same cycle
   always @* begin
      next_level = level_a;
      if (reset_ok)
         next_level = `SLZ_LVL_NONE; // RL20
      if (level_a == `SLZ_LVL_1 && !i_moving && !reset_ok)
         next_level = `SLZ_LVL_2; // RL12
      if (i_defect && i_defect_level > next_level)
         next_level = i_defect_level; // RL21
   end

   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         level_a     <= `SLZ_LVL_NONE;
         level_b     <= `SLZ_LVL_NONE;
         start_level <= `SLZ_LVL_NONE;
         started     <= 1'b0;
         contacts_ok <= 1'b0;
         o_nv_write  <= 1'b0;
         o_nv_level  <= `SLZ_LVL_NONE;
         o_stop_travel <= 1'b0;
      end else if (!started) begin
         // contacts stay open until the stored level is known
         if (i_nv_valid) begin
            level_a     <= i_nv_level; // RL14
            level_b     <= i_nv_level; // RL15
            start_level <= i_nv_level; // RL16
            started     <= 1'b1;
            contacts_ok <= 1'b1;
         end
      end else begin
         level_a       <= next_level; // RL15
         level_b       <= next_level; // RL15
         o_nv_write    <= (next_level != level_a); // RL14
         o_nv_level    <= next_level;
         o_stop_travel <= (next_level == `SLZ_LVL_1) && i_moving; // RL12
      end
   end

   // a contact output is high when closed; unpowered logic reads low, so all open
   assign o_primary_actuator_contact   = contacts_ok && level_a < `SLZ_LVL_2; // RL13 RL18
   assign o_secondary_actuator_contact = contacts_ok && level_a < `SLZ_LVL_3; // RL13 RL18
   assign o_governor_actuator_contact  = contacts_ok && level_a < `SLZ_LVL_4; // RL13 RL18

   // -----------------------------
   // read port
   // -----------------------------
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         if (i_addr == `SLZ_REG_UF_OFS)          o_rdata <= {16'h0, uf_ofs}; // RL11
         else if (i_addr == `SLZ_REG_LF_OFS)     o_rdata <= {16'h0, lf_ofs}; // RL11
         else if (i_addr == `SLZ_REG_UI_OFS)     o_rdata <= {16'h0, ui_ofs}; // RL11
         else if (i_addr == `SLZ_REG_LI_OFS)     o_rdata <= {16'h0, li_ofs}; // RL11
         else if (i_addr == `SLZ_REG_LVL_ZONE)   o_rdata <= {16'h0, lvl_zone}; // RL11
         else if (i_addr == `SLZ_REG_RELVL_ZONE) o_rdata <= {16'h0, relvl_zone}; // RL11
         else if (i_addr == `SLZ_REG_IND_DIST)   o_rdata <= {16'h0, ind_dist}; // RL11
         else if (i_addr == `SLZ_REG_MODE)       o_rdata <= {30'h0, mode};
         else if (i_addr == `SLZ_REG_STATUS)     o_rdata <= {29'h0, level_a}; // RL19
         else if (i_addr == `SLZ_REG_DEFECT_A)   o_rdata <= {21'h0, start_level, 5'h0, level_a}; // RL16
         else if (i_addr == `SLZ_REG_DEFECT_B)   o_rdata <= {21'h0, start_level, 5'h0, level_b}; // RL16
         else if (i_addr == `SLZ_REG_UF_POS)     o_rdata <= {{(32-PW){1'b0}}, uf_pos};
         else if (i_addr == `SLZ_REG_LF_POS)     o_rdata <= {{(32-PW){1'b0}}, lf_pos};
         else if (i_addr == `SLZ_REG_UI_POS)     o_rdata <= {{(32-PW){1'b0}}, ui_pos};
         else if (i_addr == `SLZ_REG_LI_POS)     o_rdata <= {{(32-PW){1'b0}}, li_pos};
         else                                    o_rdata <= 32'h0;
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule // slz_core
`default_nettype wire

// *** slz_core_assertions.sv ***
// assertion checker bound to the shaft limit, zone and error core
`timescale 1ns/1ps
`default_nettype none
module slz_core_chk #(
   parameter PW      = 24,
   parameter CNT_MAX = 20
) (
   input wire logic          i_ref_clk,
   input wire logic          i_rst,
   input wire logic          i_rd,
   input wire logic [31:0]   o_rdata,
   input wire logic [PW-1:0] i_pos,
   input wire logic [PW-1:0] i_flush_near,
   input wire logic          i_defect,
   input wire logic [2:0]    i_defect_level,
   input wire logic          i_moving,
   input wire logic          o_nv_write,
   input wire logic [2:0]    o_nv_level,
   input wire logic          o_stop_travel,
   input wire logic          o_primary_actuator_contact,
   input wire logic          o_secondary_actuator_contact,
   input wire logic          o_governor_actuator_contact,
   input wire logic          o_in_level_zone,
   input wire logic          o_in_relevel_zone,
   input wire logic          o_buzzer,
   input wire logic          o_led,
   input wire logic [1:0]    o_mode
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   // ----------------------------------------
   // bus, contacts and levels
   // ----------------------------------------
   rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside its slot");
   pri_nest_a: assert property (o_primary_actuator_contact |-> o_secondary_actuator_contact)
      else $error("primary closed with secondary open");
   sec_nest_a: assert property (o_secondary_actuator_contact |-> o_governor_actuator_contact)
      else $error("secondary closed with governor open");
   lvl_open_a: assert property (o_nv_write && o_nv_level >= 3'h2 |-> ##[0:1] !o_primary_actuator_contact)
      else $error("primary still closed at level two");
   gov_open_a: assert property (o_nv_write && o_nv_level == 3'h4 |-> ##[0:1] !o_governor_actuator_contact)
      else $error("governor still closed at level four");
   stop_car_a: assert property (i_defect && i_defect_level == 3'h1 && i_moving && o_primary_actuator_contact
      |-> ##[1:2] o_stop_travel)
      else $error("travel not stopped at level one");
   no_lower_a: assert property (o_nv_write && o_nv_level != 3'h0 |-> o_nv_level >= $past(o_nv_level))
      else $error("stored level lowered");
   mode_gate_a: assert property ($changed(o_mode) && o_mode != 2'h0 |-> o_primary_actuator_contact)
      else $error("mode switched during error");
   flush_zone_a: assert property (!$past(i_rst) && $past(i_pos) == $past(i_flush_near)
      |-> o_in_level_zone && o_in_relevel_zone)
      else $error("flush position outside door zone");
   ind_pair_a: assert property (o_buzzer == o_led)
      else $error("buzzer and led differ");
   rst_open_a: assert property ($fell(i_rst) |-> !o_primary_actuator_contact && !o_governor_actuator_contact)
      else $error("contacts closed right after reset");
endmodule // slz_core_chk

bind slz_core slz_core_chk #(.PW(PW), .CNT_MAX(CNT_MAX)) slz_core_chk_i (
   .i_ref_clk, .i_rst, .i_rd, .o_rdata, .i_pos, .i_flush_near, .i_defect, .i_defect_level, .i_moving,
   .o_nv_write, .o_nv_level, .o_stop_travel, .o_primary_actuator_contact, .o_secondary_actuator_contact,
   .o_governor_actuator_contact, .o_in_level_zone, .o_in_relevel_zone, .o_buzzer, .o_led, .o_mode);
`default_nettype wire

// *** slz_defines.vh ***
// constants shared by the shaft limit / zone / error block
`ifndef SLZ_DEFINES_VH
`define SLZ_DEFINES_VH
// ----------------------------------------
// register addresses (word address = index * 4)
// ----------------------------------------
`define SLZ_REG_UF_OFS      8'h00
`define SLZ_REG_LF_OFS      8'h04
`define SLZ_REG_UI_OFS      8'h08
`define SLZ_REG_LI_OFS      8'h0c
`define SLZ_REG_LVL_ZONE    8'h10
`define SLZ_REG_RELVL_ZONE  8'h14
`define SLZ_REG_IND_DIST    8'h18
`define SLZ_REG_MODE        8'h1c
`define SLZ_REG_STATUS      8'h20
`define SLZ_REG_DEFECT_A    8'h24
`define SLZ_REG_DEFECT_B    8'h28
`define SLZ_REG_UF_POS      8'h2c
`define SLZ_REG_LF_POS      8'h30
`define SLZ_REG_UI_POS      8'h34
`define SLZ_REG_LI_POS      8'h38
// ----------------------------------------
// parameter ranges and defaults in mm
// ----------------------------------------
`define SLZ_FIN_MIN   16'h001e
`define SLZ_FIN_MAX   16'h0064
`define SLZ_FIN_DEF   16'h0032
`define SLZ_UI_MIN    16'h0514
`define SLZ_UI_MAX    16'h2710
`define SLZ_UI_DEF    16'h0514
`define SLZ_LI_MIN    16'h06a4
`define SLZ_LI_MAX    16'h2710
`define SLZ_LI_DEF    16'h06a4
`define SLZ_LZ_MIN    16'h0014
`define SLZ_LZ_MAX    16'h015e
`define SLZ_LZ_DEF    16'h00c8
`define SLZ_RZ_MIN    16'h0014
`define SLZ_RZ_MAX    16'h00c8
`define SLZ_RZ_DEF    16'h008c
`define SLZ_IND_MIN   16'h07d0
`define SLZ_IND_MAX   16'h0fa0
`define SLZ_IND_DEF   16'h07d0
// ----------------------------------------
// modes and error levels
// ----------------------------------------
`define SLZ_MODE_NORMAL  2'h0
`define SLZ_MODE_ADJUST  2'h1
`define SLZ_MODE_TEACH   2'h2
`define SLZ_LVL_NONE     3'h0
`define SLZ_LVL_1        3'h1
`define SLZ_LVL_2        3'h2
`define SLZ_LVL_3        3'h3
`define SLZ_LVL_4        3'h4
// ----------------------------------------
// reset button timing
// ----------------------------------------
`define SLZ_PRESS_MAX_MS 32'd500
`define SLZ_CLK_KHZ      32'd200000
`define SLZ_PRESSES      2'h3
`endif

// *** slz_nv_model.sv ***
// behavioural non-volatile store for the error level
`timescale 1ns/1ps
`default_nettype none
module slz_nv_model #(
   parameter LAT = 4
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic [2:0] i_level,
   output logic [2:0]      o_level,
   output logic            o_valid
);
   logic [2:0] store = 3'h0;
   int         cnt = 0;
   // the store ignores reset on purpose: it stands for a power cycle
   always @(posedge i_ref_clk) begin
      if (i_wr && !i_rst)
         store <= i_level;
      if (i_rst)
         cnt <= 0;
      else if (cnt < LAT)
         cnt <= cnt + 1;
   end
   // before the read-out settles the lines show garbage, not the level
   assign o_valid = (cnt == LAT);
   assign o_level = o_valid ? store : ~store;
endmodule // slz_nv_model
`default_nettype wire

// *** slz_reset_seq.v ***
// triple short press detector for the manual error reset button
`timescale 1ns/1ps
`default_nettype none
`include "slz_defines.vh"
module slz_reset_seq #(
   parameter CNT_MAX = `SLZ_PRESS_MAX_MS * `SLZ_CLK_KHZ
) (
   input  wire i_ref_clk,
   input  wire i_rst,
   input  wire i_btn,
   output reg  o_reset_ok
);
   reg [1:0]  btn_sync;
   reg        btn_q;
   reg [31:0] cnt;
   reg [1:0]  presses;
   reg        armed;
   localparam [31:0] LIMIT = CNT_MAX;

   // -----------------------------
   // synchroniser and sequencer
   // -----------------------------
   // every press under limit, every gap not over limit; any violation restarts the count
   always @(posedge i_ref_clk) begin
      if (i_rst) begin
         btn_sync   <= 2'h0;
         btn_q      <= 1'b0;
         cnt        <= 32'h0;
         presses    <= 2'h0;
         armed      <= 1'b0;
         o_reset_ok <= 1'b0;
      end else begin
         btn_sync   <= {btn_sync[0], i_btn};
         btn_q      <= btn_sync[1];
         o_reset_ok <= 1'b0;
         if (cnt != 32'hffffffff)
            cnt <= cnt + 32'h1;
         if (btn_sync[1] && !btn_q) begin
            cnt <= 32'h0;
            if (armed && cnt > LIMIT)
               presses <= 2'h0;
         end else if (!btn_sync[1] && btn_q) begin
            cnt <= 32'h0;
            if (cnt < LIMIT) begin // RL20
               if (presses + 2'h1 == `SLZ_PRESSES) begin
                  o_reset_ok <= 1'b1; // RL20
                  presses    <= 2'h0;
                  armed      <= 1'b0;
               end else begin
                  presses <= presses + 2'h1;
                  armed   <= 1'b1;
               end
            end else begin
               presses <= 2'h0;
               armed   <= 1'b0;
            end
         end else if (!btn_sync[1] && armed && cnt > LIMIT) begin
            presses <= 2'h0; // gap too long
            armed   <= 1'b0;
         end
      end
   end
endmodule // slz_reset_seq
`default_nettype wire

// *** tb_slz_core.sv ***
// self-checking bench for the shaft limit, zone and error core
`timescale 1ns/1ps
`default_nettype none
`include "slz_defines.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module tb_slz_core;
   logic        i_ref_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_ref_valid = 1'b0;
   logic        i_moving = 1'b0, i_defect = 1'b0, i_reset_btn = 1'b0;
   logic [7:0]  i_addr = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic [23:0] i_pos = 24'h008000, i_flush_high = 24'h010000, i_flush_low = 24'h002000;
   logic [23:0] i_flush_near = 24'h008000, i_ref_upper = 24'h00f000, i_ref_lower = 24'h003000;
   logic [2:0]  i_defect_level = 3'h0;
   wire  [31:0] o_rdata;
   wire  [2:0]  i_nv_level, o_nv_level;
   wire  [1:0]  o_mode;
   wire         i_nv_valid, o_nv_write, o_stop_travel, o_in_level_zone, o_in_relevel_zone, o_buzzer, o_led;
   wire         o_primary_actuator_contact, o_secondary_actuator_contact, o_governor_actuator_contact;
   int          errors = 0, compares = 0, cycles = 0;
   logic [15:0] pmn [7] = '{`SLZ_FIN_MIN, `SLZ_FIN_MIN, `SLZ_UI_MIN, `SLZ_LI_MIN, `SLZ_LZ_MIN, `SLZ_RZ_MIN, `SLZ_IND_MIN};
   logic [15:0] pmx [7] = '{`SLZ_FIN_MAX, `SLZ_FIN_MAX, `SLZ_UI_MAX, `SLZ_LI_MAX, `SLZ_LZ_MAX, `SLZ_RZ_MAX, `SLZ_IND_MAX};
   logic [15:0] pdf [7] = '{`SLZ_FIN_DEF, `SLZ_FIN_DEF, `SLZ_UI_DEF, `SLZ_LI_DEF, `SLZ_LZ_DEF, `SLZ_RZ_DEF, `SLZ_IND_DEF};

   // short press window keeps the button sequence to a few dozen cycles
   slz_core #(.CNT_MAX(20)) slz_core_i (
      .i_ref_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pos, .i_flush_high, .i_flush_low,
      .i_flush_near, .i_ref_upper, .i_ref_lower, .i_ref_valid, .i_moving, .i_defect, .i_defect_level,
      .i_nv_level, .i_nv_valid, .o_nv_write, .o_nv_level, .i_reset_btn, .o_stop_travel,
      .o_primary_actuator_contact, .o_secondary_actuator_contact, .o_governor_actuator_contact,
      .o_in_level_zone, .o_in_relevel_zone, .o_buzzer, .o_led, .o_mode);
   slz_nv_model slz_nv_model_i (.i_ref_clk, .i_rst, .i_wr(o_nv_write), .i_level(o_nv_level),
      .o_level(i_nv_level), .o_valid(i_nv_valid));

   // ----------------------------------------
   // clock, timeout and bus tasks
   // ----------------------------------------
   initial forever #2.5 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         errors++;
         summarize();
      end
   end
   task automatic summarize();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   // every task but summarize syncs to a rising edge first, so strobes never double up
   task automatic settle(input int n);
      repeat (n) @(posedge i_ref_clk);
      @(negedge i_ref_clk);
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string n);
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      `CHK(n, e, o_rdata)
   endtask
   task automatic zone(input logic [23:0] p, input logic el, input logic er, input logic bz);
      @(posedge i_ref_clk);
      i_pos <= p;
      settle(2);
      `CHK("level zone", el, o_in_level_zone)
      `CHK("relevel zone", er, o_in_relevel_zone)
      `CHK("buzzer", bz, o_buzzer)
   endtask
   task automatic defect(input logic [2:0] l);
      @(posedge i_ref_clk);
      i_defect <= 1'b1;
      i_defect_level <= l;
      @(posedge i_ref_clk);
      i_defect <= 1'b0;
      settle(3);
   endtask
   // presses of five cycles and gaps of six stay inside the twenty cycle window
   task automatic press(input int n);
      repeat (n) begin
         @(posedge i_ref_clk);
         i_reset_btn <= 1'b1;
         repeat (5) @(posedge i_ref_clk);
         i_reset_btn <= 1'b0;
         repeat (5) @(posedge i_ref_clk);
      end
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_params();
      for (int i = 0; i < 7; i++) begin
         wr_reg(8'(4 * i), {16'h0, pmn[i] - 16'h1});
         wr_reg(8'(4 * i), {16'h0, pmx[i] + 16'h1});
         rd_chk(8'(4 * i), {16'h0, pdf[i]}, "param default");
         wr_reg(8'(4 * i), {16'h0, pmx[i]});
         rd_chk(8'(4 * i), {16'h0, pmx[i]}, "param max");
         wr_reg(8'(4 * i), {16'h0, pmn[i]});
         rd_chk(8'(4 * i), {16'h0, pmn[i]}, "param min");
         wr_reg(8'(4 * i), {16'h0, pdf[i]});
      end
      rd_chk(8'h3c, 32'h0, "unmapped");
      wr_reg(`SLZ_REG_UF_OFS, 32'h00010040);
      rd_chk(`SLZ_REG_UF_OFS, {16'h0, `SLZ_FIN_DEF}, "wide value");
   endtask
   task automatic t_limits();
      rd_chk(`SLZ_REG_UF_POS, {8'h0, i_flush_high + `SLZ_FIN_DEF}, "upper final");
      rd_chk(`SLZ_REG_LF_POS, {8'h0, i_flush_low - `SLZ_FIN_DEF}, "lower final");
      rd_chk(`SLZ_REG_UI_POS, {8'h0, i_flush_high - `SLZ_UI_DEF}, "upper insp");
      rd_chk(`SLZ_REG_LI_POS, {8'h0, i_flush_low + `SLZ_LI_DEF}, "lower insp");
      @(posedge i_ref_clk);
      i_ref_valid <= 1'b1;
      wr_reg(`SLZ_REG_MODE, {30'h0, `SLZ_MODE_TEACH});
      rd_chk(`SLZ_REG_UF_POS, {8'h0, i_ref_upper}, "teach upper final");
      rd_chk(`SLZ_REG_LF_POS, {8'h0, i_ref_lower}, "teach lower final");
      rd_chk(`SLZ_REG_UI_POS, {8'h0, i_ref_upper - `SLZ_UI_DEF}, "teach upper insp");
      rd_chk(`SLZ_REG_LI_POS, {8'h0, i_ref_lower + `SLZ_LI_DEF}, "teach lower insp");
      wr_reg(`SLZ_REG_MODE, {30'h0, `SLZ_MODE_NORMAL});
   endtask
   task automatic t_errors();
      @(posedge i_ref_clk);
      i_moving <= 1'b1;
      defect(`SLZ_LVL_1);
      `CHK("stop", 1'b1, o_stop_travel)
      `CHK("primary", 1'b1, o_primary_actuator_contact)
      @(posedge i_ref_clk);
      i_moving <= 1'b0;
      settle(3);
      rd_chk(`SLZ_REG_STATUS, 32'h2, "standstill level");
      `CHK("secondary", 1'b1, o_secondary_actuator_contact)
      `CHK("primary", 1'b0, o_primary_actuator_contact)
      defect(`SLZ_LVL_1);
      rd_chk(`SLZ_REG_STATUS, 32'h2, "kept level");
      wr_reg(`SLZ_REG_MODE, {30'h0, `SLZ_MODE_ADJUST});
      settle(1);
      `CHK("mode", `SLZ_MODE_NORMAL, o_mode)
      defect(`SLZ_LVL_3);
      `CHK("secondary", 1'b0, o_secondary_actuator_contact)
      `CHK("governor", 1'b1, o_governor_actuator_contact)
      defect(`SLZ_LVL_4);
      `CHK("governor", 1'b0, o_governor_actuator_contact)
      rd_chk(`SLZ_REG_DEFECT_A, 32'h4, "defect a");
      rd_chk(`SLZ_REG_DEFECT_B, 32'h4, "defect b");
   endtask
   task automatic t_power();
      @(posedge i_ref_clk);
      i_rst <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      settle(12);
      `CHK("governor", 1'b0, o_governor_actuator_contact)
      rd_chk(`SLZ_REG_DEFECT_A, 32'h404, "start level a");
      rd_chk(`SLZ_REG_DEFECT_B, 32'h404, "start level b");
      press(2);
      settle(30);
      `CHK("two presses", 1'b0, o_governor_actuator_contact)
      press(1);
      settle(30);
      `CHK("late third press", 1'b0, o_governor_actuator_contact)
      press(3);
      settle(6);
      `CHK("primary", 1'b1, o_primary_actuator_contact)
      `CHK("governor", 1'b1, o_governor_actuator_contact)
      rd_chk(`SLZ_REG_STATUS, 32'h0, "cleared level");
      rd_chk(`SLZ_REG_DEFECT_A, 32'h400, "cleared a");
      `CHK("stored level", 3'h0, i_nv_level)
   endtask

   initial begin
      repeat (6) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      settle(10);
      t_params();
      t_limits();
      zone(i_flush_near + `SLZ_LZ_DEF, 1'b1, 1'b0, 1'b0);
      zone(i_flush_near - `SLZ_RZ_DEF, 1'b1, 1'b1, 1'b0);
      zone(i_flush_near + `SLZ_LZ_DEF + 24'h1, 1'b0, 1'b0, 1'b0);
      zone(i_flush_high - `SLZ_UI_DEF - 24'h3e8, 1'b0, 1'b0, 1'b1);
      zone(i_flush_near, 1'b1, 1'b1, 1'b0);
      t_errors();
      t_power();
      summarize();
   end
endmodule // tb_slz_core
`default_nettype wire
